// File: logic/tmc_dual_timer.sv
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module tmc_dual_timer (
    input  wire logic                        sys_clk,        // fc
    input  wire logic                        reset,          // Synchronous, active high
    input  wire logic [tmc_pkg::ADDR_W-1:0]  regAddr,        // Register index
    input  wire logic [tmc_pkg::DATA_W-1:0]  regWrData,      // Write data
    input  wire logic                        regWrStrobe,    // Write strobe
    input  wire logic                        regRdStrobe,    // Read strobe
    output logic      [tmc_pkg::DATA_W-1:0]  regRdData,      // Read data, one cycle later
    input  wire logic [1:0]                  eventCountPin,  // External count pins
    output logic      [1:0]                  dividerOutPin,  // Divider outputs, inverted toggle
    output logic                             irq             // Level interrupt
);
    import tmc_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]       unitControl [2];
    logic [7:0]       unitCompare [2];
    logic [7:0]       unitCount   [2];
    logic [1:0]       toggleFf;
    logic [1:0]       irqStatus;
    logic [1:0]       irqMask;
    logic [1:0]       matchEvent;
    logic [1:0]       next_irqStatus;
    logic [PRE_W-1:0] prescale;
    logic [2:0]       pinSync [2];
    logic [1:0]       pinLevel;
    logic [1:0]       pinFall;
    logic [1:0]       ctlWrite;
    logic [1:0]       cmpWrite;
    logic             cascade;
    logic             wideHit;

    assign ctlWrite[0] = regWrStrobe && (regAddr == OFS_LOWER_CONTROL);
    assign ctlWrite[1] = regWrStrobe && (regAddr == OFS_UPPER_CONTROL);
    assign cmpWrite[0] = regWrStrobe && (regAddr == OFS_LOWER_COMPARE);
    assign cmpWrite[1] = regWrStrobe && (regAddr == OFS_UPPER_COMPARE);

    // Upper mode top bit joins the pair into one 16-bit counter
    assign cascade = unitControl[1][CTL_MODE_MSB];
    assign wideHit = ({unitCount[1], unitCount[0]} + 16'h0001) == {unitCompare[1], unitCompare[0]};

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    // Free running and cleared only by reset, so the first tick after start may come early
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + 11'h001;
        end
    end

    // Prescaler passed in so a continuous assign re-evaluates on every count
    function automatic logic selTick(input logic [2:0] sel, input logic fall, input logic [PRE_W-1:0] pre);
        logic t;
        t = 1'b0;
        case (sel)
            CLK_DIV2048: t = &pre[TAP_DIV2048-1:0];
            CLK_DIV128:  t = &pre[TAP_DIV128-1:0];
            CLK_DIV32:   t = &pre[TAP_DIV32-1:0];
            CLK_DIV8:    t = &pre[TAP_DIV8-1:0];
            CLK_DIV2:    t = pre[0];
            CLK_UNDIV:   t = 1'b1;
            CLK_PIN:     t = fall;
            default:     t = 1'b0;
        endcase
        return t;
    endfunction

    // ------------------------------------------------------------
    // Per-unit logic
    // ------------------------------------------------------------
    logic [1:0] runEff;
    logic [1:0] srcTick;
    logic [1:0] step;
    logic [1:0] next_toggle;

    for (genvar i = 0; i < 2; i++) begin : g_unit
        logic [7:0] countInc;
        logic [2:0] mode;

        assign countInc = unitCount[i] + 8'h01;
        assign mode     = unitControl[i][CTL_MODE_MSB:CTL_MODE_LSB];

        // Count pin: three stages, level changes once stages two and three agree
        always_ff @(posedge sys_clk) begin
            if (reset) begin
                pinSync[i]  <= 3'h7;
                pinLevel[i] <= 1'b1;
            end else begin
                pinSync[i] <= {pinSync[i][1:0], eventCountPin[i]};
                if (pinSync[i][1] == pinSync[i][2]) begin
                    pinLevel[i] <= pinSync[i][2];
                end
            end
        end
        assign pinFall[i] = pinLevel[i] && !pinSync[i][1] && !pinSync[i][2];

        if (i == 0) begin : g_lo
            assign runEff[i]  = cascade ? unitControl[1][CTL_RUN_BIT] : unitControl[0][CTL_RUN_BIT];
            assign srcTick[i] = selTick(unitControl[0][CTL_CLK_MSB:CTL_CLK_LSB], pinFall[0], prescale);
        end else begin : g_hi
            assign runEff[i]  = unitControl[1][CTL_RUN_BIT];
            // Carry from the lower byte replaces the upper clock select
            assign srcTick[i] = cascade ? (srcTick[0] && (unitCount[0] == COUNT_TOP))
                                        : selTick(unitControl[1][CTL_CLK_MSB:CTL_CLK_LSB], pinFall[1], prescale);
        end

        assign step[i] = runEff[i] && srcTick[i];
        assign matchEvent[i] = cascade ? (step[0] && wideHit && (i == 1))
                                       : (step[i] && (countInc == unitCompare[i]));

        always_ff @(posedge sys_clk) begin
            if (reset) begin
                unitCount[i] <= 8'h00;
            end else if (cascade ? (step[0] && wideHit) : matchEvent[i]) begin
                unitCount[i] <= 8'h00;
            end else if (step[i]) begin
                unitCount[i] <= countInc;
            end
        end

        always_ff @(posedge sys_clk) begin
            if (reset) begin
                unitControl[i] <= RST_CONTROL;
            end else if (ctlWrite[i]) begin
                unitControl[i] <= regWrData;
            end
        end

        // No shadow stage: compare sees the new value on the next cycle
        always_ff @(posedge sys_clk) begin
            if (reset) begin
                unitCompare[i] <= RST_COMPARE;
            end else if (cmpWrite[i]) begin
                unitCompare[i] <= regWrData;
            end
        end

        always_comb begin
            next_toggle[i] = toggleFf[i];
            if (ctlWrite[i] && !unitControl[i][CTL_RUN_BIT]) begin
                next_toggle[i] = regWrData[CTL_TOGGLE_BIT];
            end else if (matchEvent[i] && !cascade && (mode == MODE_DIVIDER)) begin
                next_toggle[i] = !toggleFf[i];
            end
        end

        always_ff @(posedge sys_clk) begin
            if (reset) begin
                toggleFf[i]      <= RST_TOGGLE;
                dividerOutPin[i] <= !RST_TOGGLE;
            end else begin
                toggleFf[i]      <= next_toggle[i];
                dividerOutPin[i] <= !next_toggle[i];
            end
        end

        // --------------------------------------------------------
        // Checks
        // --------------------------------------------------------
        property p_timer_match;
            @(posedge sys_clk) disable iff (reset)
            (step[i] && !cascade && (countInc == unitCompare[i])) |=> (unitCount[i] == 8'h00) && irqStatus[i];
        endproperty
        a_timer_match: assert property (p_timer_match) else $error("match did not clear and flag");

        property p_event_step;
            @(posedge sys_clk) disable iff (reset)
            (runEff[i] && !cascade && (unitControl[i][CTL_CLK_MSB:CTL_CLK_LSB] == CLK_PIN) && pinFall[i]
             && !matchEvent[i]) |=> (unitCount[i] == $past(unitCount[i]) + 8'h01);
        endproperty
        a_event_step: assert property (p_event_step) else $error("falling edge not counted");

        property p_divider_toggle;
            @(posedge sys_clk) disable iff (reset)
            (matchEvent[i] && !cascade && (mode == MODE_DIVIDER) && !ctlWrite[i])
                |=> (toggleFf[i] != $past(toggleFf[i])) && (dividerOutPin[i] == !toggleFf[i]);
        endproperty
        a_divider_toggle: assert property (p_divider_toggle) else $error("divider did not toggle");

        property p_reset_toggle;
            @(posedge sys_clk) $past(reset) |-> (toggleFf[i] == 1'b0) && dividerOutPin[i];
        endproperty
        a_reset_toggle: assert property (p_reset_toggle) else $error("toggle not cleared by reset");

        property p_pin_complement;
            @(posedge sys_clk) disable iff (reset) dividerOutPin[i] == !toggleFf[i];
        endproperty
        a_pin_complement: assert property (p_pin_complement) else $error("pin not complement of toggle");

        sequence s_stopped_quiet;
            !unitControl[i][CTL_RUN_BIT] && !ctlWrite[i];
        endsequence
        sequence s_preset_write;
            ctlWrite[i] && !unitControl[i][CTL_RUN_BIT];
        endsequence

        property p_stop_hold;
            @(posedge sys_clk) disable iff (reset)
            s_stopped_quiet ##1 s_stopped_quiet |-> $stable(dividerOutPin[i]);
        endproperty
        a_stop_hold: assert property (p_stop_hold) else $error("stopped pin changed level");

        property p_preset;
            @(posedge sys_clk) disable iff (reset)
            s_preset_write |=> (dividerOutPin[i] == !$past(regWrData[CTL_TOGGLE_BIT]));
        endproperty
        a_preset: assert property (p_preset) else $error("preset write ignored");

        property p_compare_now;
            @(posedge sys_clk) disable iff (reset)
            cmpWrite[i] |=> (unitCompare[i] == $past(regWrData));
        endproperty
        a_compare_now: assert property (p_compare_now) else $error("compare write delayed");

        property p_idle;
            @(posedge sys_clk) disable iff (reset)
            !runEff[i] |=> $stable(unitCount[i]) && !(irqStatus[i] && !$past(irqStatus[i]));
        endproperty
        a_idle: assert property (p_idle) else $error("stopped unit moved");
    end

    property p_cascade_carry;
        @(posedge sys_clk) disable iff (reset)
        (cascade && $past(cascade && runEff[1] && !(step[0] && wideHit))
         && (unitCount[1] != $past(unitCount[1])))
            |-> $past(srcTick[0] && (unitCount[0] == COUNT_TOP));
    endproperty
    a_cascade_carry: assert property (p_cascade_carry) else $error("upper moved without carry");

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    // Set wins over a write-one clear in the same cycle
    always_comb begin
        next_irqStatus = irqStatus;
        if (regWrStrobe && (regAddr == OFS_IRQ_STATUS)) begin
            next_irqStatus = irqStatus & ~regWrData[1:0];
        end
        next_irqStatus = next_irqStatus | matchEvent;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irqStatus <= RST_IRQ;
            irq       <= 1'b0;
        end else begin
            irqStatus <= next_irqStatus;
            irq       <= |(next_irqStatus & irqMask);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irqMask <= RST_IRQ;
        end else if (regWrStrobe && (regAddr == OFS_IRQ_MASK)) begin
            irqMask <= regWrData[1:0];
        end
    end

    // Mask change reaches irq one cycle after the mask register updates
    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            regRdData <= 8'h00;
        end else if (regRdStrobe) begin
            if (regAddr == OFS_LOWER_CONTROL) begin
                regRdData <= unitControl[0];
            end else if (regAddr == OFS_UPPER_CONTROL) begin
                regRdData <= unitControl[1];
            end else if (regAddr == OFS_LOWER_COMPARE) begin
                regRdData <= unitCompare[0];
            end else if (regAddr == OFS_UPPER_COMPARE) begin
                regRdData <= unitCompare[1];
            end else if (regAddr == OFS_IRQ_STATUS) begin
                regRdData <= {6'h00, irqStatus};
            end else if (regAddr == OFS_IRQ_MASK) begin
                regRdData <= {6'h00, irqMask};
            end else begin
                regRdData <= 8'h00;
            end
        end else begin
            regRdData <= 8'h00;
        end
    end
endmodule

// File: logic/tmc_pkg.sv
package tmc_pkg;
    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;
    localparam logic [2:0] OFS_LOWER_CONTROL = 3'h0;
    localparam logic [2:0] OFS_UPPER_CONTROL = 3'h1;
    localparam logic [2:0] OFS_LOWER_COMPARE = 3'h2;
    localparam logic [2:0] OFS_UPPER_COMPARE = 3'h3;
    localparam logic [2:0] OFS_IRQ_STATUS    = 3'h4;
    localparam logic [2:0] OFS_IRQ_MASK      = 3'h5;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int unsigned CTL_TOGGLE_BIT = 7;
    localparam int unsigned CTL_CLK_MSB    = 6;
    localparam int unsigned CTL_CLK_LSB    = 4;
    localparam int unsigned CTL_RUN_BIT    = 3;
    localparam int unsigned CTL_MODE_MSB   = 2;
    localparam int unsigned CTL_MODE_LSB   = 0;

    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_COMPARE = 8'h00;
    localparam logic [1:0] RST_IRQ     = 2'h0;
    localparam logic       RST_TOGGLE  = 1'b0;

    // Mode field encodings
    localparam logic [2:0] MODE_TIMER      = 3'h0;
    localparam logic [2:0] MODE_DIVIDER    = 3'h1;
    localparam logic [2:0] MODE_MODULATOR  = 3'h2;
    localparam logic [2:0] MODE_CASCADE_LO = 3'h3;

    // Clock select encodings
    localparam logic [2:0] CLK_DIV2048 = 3'h0;
    localparam logic [2:0] CLK_DIV128  = 3'h1;
    localparam logic [2:0] CLK_DIV32   = 3'h2;
    localparam logic [2:0] CLK_DIV8    = 3'h3;
    localparam logic [2:0] CLK_DIV2    = 3'h4;
    localparam logic [2:0] CLK_UNDIV   = 3'h5;
    localparam logic [2:0] CLK_PIN     = 3'h6;

    // Prescaler taps
    localparam int unsigned PRE_W       = 11;
    localparam int unsigned TAP_DIV2048 = 11;
    localparam int unsigned TAP_DIV128  = 7;
    localparam int unsigned TAP_DIV32   = 5;
    localparam int unsigned TAP_DIV8    = 3;

    localparam logic [7:0] COUNT_TOP = 8'hff;
endpackage

// File: sim/tmc_dual_timer_test.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_total++; \
    $display("MISMATCH at %0t: got %h expected %h", $time, (got), (exp)); end end
module tmc_dual_timer_test;
    import tmc_pkg::*;
    localparam int LIMIT = 30000;
    logic       sys_clk     = 1'b0;
    logic       reset       = 1'b1;
    logic [2:0] regAddr     = 3'h0;
    logic [7:0] regWrData   = 8'h00;
    logic       regWrStrobe = 1'b0;
    logic       regRdStrobe = 1'b0;
    logic [7:0] regRdData;
    logic [1:0] eventCountPin;
    logic [1:0] dividerOutPin;
    logic       irq;
    int         err_total   = 0;
    int         compares    = 0;
    int         cyc         = 0;
    int         p;
    int         t;
    logic       pinWas;

    always #4 sys_clk = ~sys_clk;

    tmc_dual_timer u_dut (.sys_clk(sys_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
        .eventCountPin(eventCountPin), .dividerOutPin(dividerOutPin), .irq(irq));
    tmc_event_source u_src (.sys_clk(sys_clk), .pinLevel(eventCountPin));

    // --------------------------------------------------------
    // Bus tasks
    // --------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Idle cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStrobe <= 1'b1;
        @(posedge sys_clk);
        regWrStrobe <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        regAddr <= a;
        regRdStrobe <= 1'b1;
        @(posedge sys_clk);
        regRdStrobe <= 1'b0;
        #1;
        `CHK(regRdData, exp)
    endtask

    task automatic wait_irq(output int when);
        int n;
        n = 0;
        tick(2);
        while (irq !== 1'b1 && n < 8000) begin
            tick(1);
            n++;
        end
        if (irq !== 1'b1) begin
            err_total++;
            $display("MISMATCH at %0t: interrupt wait timed out", $time);
        end
        when = cyc;
    endtask

    // First clear drops any stale status, so both rises are real matches
    task automatic period(output int len);
        int a;
        int b;
        wr(OFS_IRQ_STATUS, 8'h03);
        wait_irq(a);
        wr(OFS_IRQ_STATUS, 8'h03);
        wait_irq(b);
        len = b - a;
    endtask

    task automatic stop_test;
        if (err_total == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_total++;
            stop_test();
        end
    end

    // --------------------------------------------------------
    // Sequence
    // --------------------------------------------------------
    initial begin
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        tick(1);
        `CHK(dividerOutPin, 2'b11)
        `CHK(irq, 1'b0)
        wr(3'h7, 8'hff);
        for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
        wr(OFS_LOWER_COMPARE, 8'h5a);
        rd(OFS_LOWER_COMPARE, 8'h5a);
        // Divider on the upper unit, divide-by-128
        wr(OFS_UPPER_COMPARE, 8'h03);
        wr(OFS_UPPER_CONTROL, 8'h11);
        rd(OFS_UPPER_CONTROL, 8'h11);
        wr(OFS_IRQ_MASK, 8'h02);
        wr(OFS_UPPER_CONTROL, 8'h19);
        period(p);
        `CHK(p, 3 * (1 << TAP_DIV128))
        pinWas = dividerOutPin[1];
        wr(OFS_IRQ_STATUS, 8'h02);
        wait_irq(t);
        `CHK(dividerOutPin[1], ~pinWas)
        // Stop holds the pin; preset only after the stop
        wr(OFS_UPPER_CONTROL, 8'h11);
        tick(1);
        pinWas = dividerOutPin[1];
        wr(OFS_IRQ_STATUS, 8'h03);
        tick(600);
        `CHK(dividerOutPin[1], pinWas)
        rd(OFS_IRQ_STATUS, 8'h00);
        wr(OFS_UPPER_CONTROL, 8'h91);
        tick(1);
        `CHK(dividerOutPin[1], 1'b0)
        wr(OFS_UPPER_CONTROL, 8'h11);
        tick(1);
        `CHK(dividerOutPin[1], 1'b1)
        // Lower timer, divide-by-8, masked first
        wr(OFS_IRQ_MASK, 8'h00);
        wr(OFS_LOWER_COMPARE, 8'h04);
        wr(OFS_LOWER_CONTROL, 8'h38);
        tick(100);
        `CHK(irq, 1'b0)
        rd(OFS_IRQ_STATUS, 8'h01);
        wr(OFS_IRQ_MASK, 8'h01);
        period(p);
        `CHK(p, 4 * (1 << TAP_DIV8))
        `CHK(dividerOutPin[0], 1'b1)
        // Event counting on the lower pin
        wr(OFS_LOWER_CONTROL, 8'h30);
        wr(OFS_LOWER_CONTROL, 8'h68);
        wr(OFS_IRQ_STATUS, 8'h03);
        repeat (4) if (irq !== 1'b1) begin
            u_src.pulse(0, 1, 2);
            tick(5);
        end
        wr(OFS_IRQ_STATUS, 8'h03);
        u_src.pulse(0, 3, 2);
        tick(6);
        rd(OFS_IRQ_STATUS, 8'h00);
        u_src.pulse(0, 1, 6);
        tick(6);
        rd(OFS_IRQ_STATUS, 8'h01);
        // Cascade: upper own clock select is 'none' and must be ignored
        wr(OFS_LOWER_CONTROL, 8'h60);
        wr(OFS_LOWER_CONTROL, 8'h33);
        wr(OFS_LOWER_COMPARE, 8'h02);
        wr(OFS_UPPER_COMPARE, 8'h02);
        wr(OFS_IRQ_MASK, 8'h03);
        wr(OFS_UPPER_CONTROL, 8'h7c);
        period(p);
        rd(OFS_IRQ_STATUS, 8'h02);
        `CHK(p, 514 * (1 << TAP_DIV8))
        `CHK(dividerOutPin, 2'b11)
        stop_test();
    end
endmodule

// File: sim/tmc_event_source.sv
`timescale 1ns/1ps
module tmc_event_source (
    input  wire logic       sys_clk,  // Same clock as the block
    output logic      [1:0] pinLevel  // Count pins, idle high
);
    initial pinLevel = 2'b11;

    // --------------------------------------------------------
    // Falling-edge pulse trains
    // --------------------------------------------------------
    // Short levels would slip through the pin filter unseen
    task automatic pulse(input int unit, input int n, input int hold);
        int h;
        h = (hold < 2) ? 2 : hold;
        repeat (n) begin
            @(posedge sys_clk);
            pinLevel[unit] <= 1'b0;
            repeat (h) @(posedge sys_clk);
            pinLevel[unit] <= 1'b1;
            repeat (h - 1) @(posedge sys_clk);
        end
    endtask
endmodule
